// File: verilog/vin_pkg.sv
/*
 * Package for the virtual input function mux: register offsets, function
 * codes, reset codes and mode values.
 * Assumes a 32-bit AHB-Lite register bus with one word per register.
 */
package vin_pkg;

	// -------------------------------------------------------------------
	// Register byte offsets
	// -------------------------------------------------------------------
	localparam logic [7:0] OFF_SEL4      = 8'h00;
	localparam logic [7:0] OFF_SEL3      = 8'h04;
	localparam logic [7:0] OFF_SEL2      = 8'h08;
	localparam logic [7:0] OFF_SEL9      = 8'h0c;
	localparam logic [7:0] OFF_SEL11     = 8'h10;
	localparam logic [7:0] OFF_MODE      = 8'h14;
	localparam logic [7:0] OFF_STATUS    = 8'h18;

	// -------------------------------------------------------------------
	// Function codes
	// -------------------------------------------------------------------
	localparam logic [15:0] FN_LOW       = 16'h0000;
	localparam logic [15:0] FN_MID       = 16'h0001;
	localparam logic [15:0] FN_HIGH      = 16'h0002;
	localparam logic [15:0] FN_SECOND    = 16'h0003;
	localparam logic [15:0] FN_REX       = 16'h0008;
	localparam logic [15:0] FN_PID       = 16'h000e;
	localparam logic [15:0] FN_BRI       = 16'h000f;
	localparam logic [15:0] FN_VF        = 16'h0012;
	localparam logic [15:0] FN_MRS       = 16'h0018;
	localparam logic [15:0] FN_RSVD62    = 16'h003e;
	localparam logic [15:0] FN_NONE      = 16'h270f;

	// -------------------------------------------------------------------
	// Reset codes of the five selectors
	// -------------------------------------------------------------------
	localparam logic [15:0] RST_SEL4     = FN_LOW;
	localparam logic [15:0] RST_SEL3     = FN_MID;
	localparam logic [15:0] RST_SEL2     = FN_HIGH;
	localparam logic [15:0] RST_SEL9     = FN_MRS;
	localparam logic [15:0] RST_SEL11    = FN_RSVD62;

	// -------------------------------------------------------------------
	// Mode register fields
	// -------------------------------------------------------------------
	localparam int          MODE_REMOTE_LSB = 0;
	localparam int          MODE_CONTACT_LSB = 2;
	localparam int          MODE_GROUP_LSB  = 4;
	localparam int          MODE_BRAKE_BIT  = 12;
	localparam logic [31:0] RST_MODE        = 32'h0000_0000;

endpackage

// File: verilog/vin_sel_regs.sv
/*
 * Holds the five function-select codes, written one at a time.
 * Assumes the caller has already qualified the write strobe.
 */
module vin_sel_regs #(
	parameter int N = 5
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              wr_en,
	input  wire logic [2:0]        wr_idx,
	input  wire logic [15:0]       wr_data,
	input  wire logic [2:0]        rd_idx,
	output logic      [15:0]       rd_data,
	output logic      [N*16-1:0]   sel_flat
);
	localparam logic [N*16-1:0] RST_ALL = {vin_pkg::RST_SEL11,
		vin_pkg::RST_SEL9, vin_pkg::RST_SEL2, vin_pkg::RST_SEL3,
		vin_pkg::RST_SEL4};

	logic [15:0] sel_reg [N];

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_sel
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					sel_reg[g] <= RST_ALL[g*16 +: 16];
				else if (wr_en && wr_idx == 3'(g))
					sel_reg[g] <= wr_data;
			end
			assign sel_flat[g*16 +: 16] = sel_reg[g];
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rd_data <= 16'h0000;
		else if (rd_idx < 3'(N))
			rd_data <= sel_reg[rd_idx];
		else
			rd_data <= 16'h0000;
	end
endmodule

// File: verilog/virtual_input_function_mux.sv
/*
 * Virtual input function mux: maps five network input bits onto drive
 * command functions, with mode rewrites and run/stop decoding.
 * Assumes an AHB-Lite master on clk, single word transfers only, and
 * network input bits arriving from another clock domain.
 */
module virtual_input_function_mux (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hsel,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        net_input_bit4,
	input  wire logic        net_input_bit3,
	input  wire logic        net_input_bit2,
	input  wire logic        net_input_bit9,
	input  wire logic        net_input_bit11,
	input  wire logic        forward_run_in,
	input  wire logic        reverse_run_in,
	input  wire logic        drive_stopped,
	output logic             low_speed_cmd,
	output logic             middle_speed_cmd,
	output logic             high_speed_cmd,
	output logic             fifteen_speed_ext,
	output logic             remote_clear,
	output logic             remote_decel,
	output logic             remote_accel,
	output logic             contact_sel0,
	output logic             contact_sel1,
	output logic             pid_speed_active,
	output logic             brake_open_complete,
	output logic             second_set_select,
	output logic             brake_seq_active,
	output logic             vf_control_active,
	output logic             output_stop_in,
	output logic             run_forward,
	output logic             run_reverse,
	output logic             decel_to_stop
);
	localparam int N = 5;

	// -------------------------------------------------------------------
	// Input synchronisers
	// -------------------------------------------------------------------
	logic [6:0] sync1_reg;
	logic [6:0] sync2_reg;
	wire  [6:0] raw_in = {reverse_run_in, forward_run_in, net_input_bit11,
		net_input_bit9, net_input_bit2, net_input_bit3, net_input_bit4};

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
		end
		else
		begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end

	wire [N-1:0] bits = sync2_reg[4:0];
	wire         fwd  = sync2_reg[5];
	wire         rev  = sync2_reg[6];

	// -------------------------------------------------------------------
	// AHB-Lite slave
	// -------------------------------------------------------------------
	logic        dp_write_reg;
	logic [7:0]  dp_addr_reg;
	logic [31:0] mode_reg;
	logic [N*16-1:0] sel_flat;

	wire take = hsel && hready && htrans[1];

	wire [1:0] remote_function_sel = mode_reg[vin_pkg::MODE_REMOTE_LSB +: 2];
	wire [1:0] stop_on_contact_sel = mode_reg[vin_pkg::MODE_CONTACT_LSB +: 2];
	wire [7:0] user_group_read_sel = mode_reg[vin_pkg::MODE_GROUP_LSB +: 8];
	wire       brake_mode          = mode_reg[vin_pkg::MODE_BRAKE_BIT];

	wire       dp_is_sel  = dp_addr_reg < vin_pkg::OFF_MODE;
	wire [2:0] dp_idx     = dp_addr_reg[4:2];
	// Writes to the selectors are silently dropped outside group 0
	wire       sel_wr_en  = dp_write_reg && dp_is_sel &&
		user_group_read_sel == 8'h00;
	wire       mode_wr_en = dp_write_reg && dp_addr_reg == vin_pkg::OFF_MODE;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dp_write_reg <= 1'b0;
			dp_addr_reg  <= 8'h00;
		end
		else
		begin
			dp_write_reg <= take && hwrite;
			dp_addr_reg  <= take ? {haddr[7:2], 2'b00} : dp_addr_reg;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			mode_reg <= vin_pkg::RST_MODE;
		else if (mode_wr_en)
			mode_reg <= {19'h00000, hwdata[12:0]};
	end

	vin_sel_regs #(
		.N        (N)
	) u_sel (
		.clk      (clk),
		.rst_n    (rst_n),
		.wr_en    (sel_wr_en),
		.wr_idx   (dp_idx),
		.wr_data  (hwdata[15:0]),
		.rd_idx   (haddr[4:2]),
		.rd_data  (),
		.sel_flat (sel_flat)
	);

	// Read word picked in the address phase so hrdata leaves a flop
	wire [7:0]  ap_addr = {haddr[7:2], 2'b00};
	wire [2:0]  ap_idx  = haddr[4:2];
	wire [15:0] ap_sel  = sel_flat[ap_idx*16 +: 16];

	wire [31:0] status_word = {24'h000000, vf_control_active,
		second_set_select, brake_seq_active, output_stop_in,
		run_reverse, run_forward, decel_to_stop, pid_speed_active};

	wire [31:0] rd_word = (ap_addr < vin_pkg::OFF_MODE) ? {16'h0000, ap_sel} :
		(ap_addr == vin_pkg::OFF_MODE) ? mode_reg :
		(ap_addr == vin_pkg::OFF_STATUS) ? status_word : 32'h0000_0000;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			hrdata <= 32'h0000_0000;
		else
			hrdata <= (take && !hwrite) ? rd_word : 32'h0000_0000;
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// -------------------------------------------------------------------
	// Function decode
	// -------------------------------------------------------------------
	function automatic logic fn_or(input logic [N*16-1:0] sel,
		input logic [N-1:0] b, input logic [15:0] code);
		logic r;
		r = 1'b0;
		for (int i = 0; i < N; i++)
			if (sel[i*16 +: 16] == code)
				r = r | b[i];
		return r;
	endfunction

	wire f_low  = fn_or(sel_flat, bits, vin_pkg::FN_LOW);
	wire f_mid  = fn_or(sel_flat, bits, vin_pkg::FN_MID);
	wire f_high = fn_or(sel_flat, bits, vin_pkg::FN_HIGH);
	wire f_rt   = fn_or(sel_flat, bits, vin_pkg::FN_SECOND);
	wire f_rex  = fn_or(sel_flat, bits, vin_pkg::FN_REX);
	wire f_pid  = fn_or(sel_flat, bits, vin_pkg::FN_PID);
	wire f_bri  = fn_or(sel_flat, bits, vin_pkg::FN_BRI);
	wire f_vf   = fn_or(sel_flat, bits, vin_pkg::FN_VF);
	wire f_mrs  = fn_or(sel_flat, bits, vin_pkg::FN_MRS);

	// Shared bits: remote and seven-speed never both set speed
	wire remote_on  = remote_function_sel == 2'd1 ||
		remote_function_sel == 2'd2;
	wire contact_on = stop_on_contact_sel == 2'd1;
	wire speed_ms   = !remote_on && (f_high || f_mid || f_rex ||
		(f_low && !contact_on));
	wire running    = !drive_stopped;

	// -------------------------------------------------------------------
	// Second set, brake and V/F state
	// -------------------------------------------------------------------
	logic vf_reg;
	logic brake_reg;
	wire  vf_next = drive_stopped ? f_vf : vf_reg;
	// Brake sequence gives way to the second set only at a stop
	wire  brake_next = !brake_mode ? 1'b0 :
		(drive_stopped ? !f_rt : brake_reg);
	wire  rt_eff = (f_rt && !contact_on && !(brake_mode && brake_reg &&
		running)) || vf_reg;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			vf_reg    <= 1'b0;
			brake_reg <= 1'b0;
		end
		else
		begin
			vf_reg    <= vf_next;
			brake_reg <= brake_next;
		end
	end

	// -------------------------------------------------------------------
	// Registered outputs
	// -------------------------------------------------------------------
	wire one_run = fwd ^ rev;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			low_speed_cmd       <= 1'b0;
			middle_speed_cmd    <= 1'b0;
			high_speed_cmd      <= 1'b0;
			fifteen_speed_ext   <= 1'b0;
			remote_clear        <= 1'b0;
			remote_decel        <= 1'b0;
			remote_accel        <= 1'b0;
			contact_sel0        <= 1'b0;
			contact_sel1        <= 1'b0;
			pid_speed_active    <= 1'b0;
			brake_open_complete <= 1'b0;
			second_set_select   <= 1'b0;
			brake_seq_active    <= 1'b0;
			vf_control_active   <= 1'b0;
			output_stop_in      <= 1'b0;
			run_forward         <= 1'b0;
			run_reverse         <= 1'b0;
			decel_to_stop       <= 1'b0;
		end
		else
		begin
			low_speed_cmd       <= f_low && !remote_on && !contact_on;
			middle_speed_cmd    <= f_mid && !remote_on;
			high_speed_cmd      <= f_high && !remote_on;
			fifteen_speed_ext   <= f_rex;
			remote_clear        <= f_low && remote_on;
			remote_decel        <= f_mid && remote_on;
			remote_accel        <= f_high && remote_on;
			contact_sel0        <= f_low && contact_on;
			contact_sel1        <= f_rt && contact_on;
			pid_speed_active    <= f_pid && !speed_ms;
			brake_open_complete <= f_bri;
			second_set_select   <= rt_eff;
			brake_seq_active    <= brake_reg;
			vf_control_active   <= vf_reg;
			output_stop_in      <= f_mrs;
			run_forward         <= fwd && !rev && !f_mrs;
			run_reverse         <= rev && !fwd && !f_mrs;
			decel_to_stop       <= running && !one_run;
		end
	end

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	property p_or_low;
		@(posedge clk) disable iff (!rst_n)
		(f_low && !remote_on && !contact_on) |=> low_speed_cmd;
	endproperty
	a_or_low: assert property (p_or_low)
		else $error("low speed not driven by assigned bit");

	property p_group_lock;
		@(posedge clk) disable iff (!rst_n)
		(dp_write_reg && dp_is_sel && user_group_read_sel != 8'h00)
		|=> $stable(sel_flat);
	endproperty
	a_group_lock: assert property (p_group_lock)
		else $error("selector changed while locked");

	property p_pid_prio;
		@(posedge clk) disable iff (!rst_n)
		speed_ms |=> !pid_speed_active;
	endproperty
	a_pid_prio: assert property (p_pid_prio)
		else $error("pid speed active over multi-speed");

	property p_remote;
		@(posedge clk) disable iff (!rst_n)
		(remote_on && f_high) |=> (remote_accel && !high_speed_cmd);
	endproperty
	a_remote: assert property (p_remote)
		else $error("remote accel not taken");

	property p_contact;
		@(posedge clk) disable iff (!rst_n)
		(contact_on && f_rt) |=> contact_sel1;
	endproperty
	a_contact: assert property (p_contact)
		else $error("contact select 1 missing");

	property p_vf_hold;
		@(posedge clk) disable iff (!rst_n)
		(running && !drive_stopped) |=> (vf_reg == $past(vf_reg));
	endproperty
	a_vf_hold: assert property (p_vf_hold)
		else $error("vf changed while running");

	property p_vf_second;
		@(posedge clk) disable iff (!rst_n)
		vf_reg |=> second_set_select;
	endproperty
	a_vf_second: assert property (p_vf_second)
		else $error("second set not forced under vf");

	property p_run;
		@(posedge clk) disable iff (!rst_n)
		(fwd && !rev && !f_mrs) |=> (run_forward && !run_reverse);
	endproperty
	a_run: assert property (p_run)
		else $error("forward run not decoded");

	property p_decel;
		@(posedge clk) disable iff (!rst_n)
		(running && fwd && rev) |=> decel_to_stop;
	endproperty
	a_decel: assert property (p_decel)
		else $error("both on did not decelerate");

	property p_mrs;
		@(posedge clk) disable iff (!rst_n)
		f_mrs |=> (output_stop_in && !run_forward && !run_reverse);
	endproperty
	a_mrs: assert property (p_mrs)
		else $error("output stop not immediate");

	c_remote: cover property (@(posedge clk) remote_on && f_mid);
	c_vf: cover property (@(posedge clk) $rose(vf_reg));
	c_rev: cover property (@(posedge clk) run_reverse);
	c_brake: cover property (@(posedge clk) brake_reg && running);
endmodule

// File: tb/net_master_model.sv
/*
 * Behavioural field-network master: drives five virtual input bits and the
 * two run inputs as levels, updated once per clock.
 * Assumes the bench supplies requests and says which bits carry V/F.
 */
module net_master_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [6:0] req,
	input  wire logic [6:0] vf_mask,
	input  wire logic       drive_stopped,
	input  wire logic       rude,
	output logic      [6:0] bits
);
	timeunit 1ns;
	timeprecision 100ps;

	// Polite master holds V/F bits while running; rude one does not
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			bits <= 7'h00;
		else if (drive_stopped || rude)
			bits <= req;
		else
			bits <= (req & ~vf_mask) | (bits & vf_mask);
	end
endmodule

// File: tb/test_virtual_input_function_mux.sv
/*
 * Self-checking bench for the virtual input function mux.
 * Assumes the mux answers the bus with no wait states and that input
 * changes show at the outputs within five clock edges.
 */
module test_virtual_input_function_mux;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic        hsel = 1'b0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [6:0]  req = 7'h00;
	logic [6:0]  vf_mask = 7'h00;
	logic        rude = 1'b0;
	logic        drive_stopped = 1'b1;
	logic [6:0]  bits;
	logic [17:0] outs;
	int          n_fail = 0;
	int          n_tests = 0;

	always #5 clk = ~clk;

	net_master_model partner (
		.clk          (clk),
		.rst_n        (rst_n),
		.req          (req),
		.vf_mask      (vf_mask),
		.drive_stopped(drive_stopped),
		.rude         (rude),
		.bits         (bits)
	);

	virtual_input_function_mux uut (
		.clk(clk), .rst_n(rst_n), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .net_input_bit4(bits[0]), .net_input_bit3(bits[1]),
		.net_input_bit2(bits[2]), .net_input_bit9(bits[3]),
		.net_input_bit11(bits[4]), .forward_run_in(bits[5]),
		.reverse_run_in(bits[6]), .drive_stopped(drive_stopped),
		.low_speed_cmd(outs[0]), .middle_speed_cmd(outs[1]),
		.high_speed_cmd(outs[2]), .fifteen_speed_ext(outs[3]),
		.remote_clear(outs[4]), .remote_decel(outs[5]),
		.remote_accel(outs[6]), .contact_sel0(outs[7]),
		.contact_sel1(outs[8]), .second_set_select(outs[9]),
		.pid_speed_active(outs[10]), .brake_open_complete(outs[11]),
		.vf_control_active(outs[12]), .output_stop_in(outs[13]),
		.decel_to_stop(outs[14]), .run_forward(outs[15]),
		.run_reverse(outs[16]), .brake_seq_active(outs[17])
	);

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic give_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Bounded wait for hready sampled high at a rising edge
	task automatic hwait;
		int i;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (hreadyout !== 1'b1 && i < 50);
		if (hreadyout !== 1'b1)
		begin
			n_fail++;
			give_verdict();
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		hsel <= 1'b1;
		hwait();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		hwait();
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(r, exp);
	endtask

	// Partner, two sync flops and output flop; the V/F latch adds one
	task automatic drive_check(input logic [6:0] v, input logic [31:0] exp);
		req <= v;
		repeat (5) @(posedge clk);
		#1;
		check({14'h0, outs}, exp);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset;
		check({14'h0, outs}, 32'h0);
		rd_check(vin_pkg::OFF_SEL4, 32'h0000);
		rd_check(vin_pkg::OFF_SEL3, 32'h0001);
		rd_check(vin_pkg::OFF_SEL2, 32'h0002);
		rd_check(vin_pkg::OFF_SEL9, 32'h0018);
		rd_check(vin_pkg::OFF_SEL11, 32'h003e);
		rd_check(vin_pkg::OFF_MODE, 32'h0);
		wr(8'h1c, 32'h5);
		rd_check(8'h1c, 32'h0);
	endtask

	task automatic t_defaults;
		drive_check(7'h07, 32'h0007);
		drive_check(7'h18, 32'h2000);
		drive_check(7'h10, 32'h0000);
	endtask

	task automatic t_codes;
		logic [15:0] c [10] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003,
			16'h0008, 16'h000e, 16'h000f, 16'h0012, 16'h0018, 16'h270f};
		logic [31:0] e [10] = '{32'h1, 32'h2, 32'h4, 32'h200, 32'h8,
			32'h400, 32'h800, 32'h1200, 32'h2000, 32'h0};
		for (int k = 0; k < 10; k++)
		begin
			wr(vin_pkg::OFF_SEL11, {16'h0, c[k]});
			rd_check(vin_pkg::OFF_SEL11, {16'h0, c[k]});
			drive_check(7'h10, e[k]);
			drive_check(7'h00, 32'h0);
		end
	endtask

	task automatic t_or_pid;
		wr(vin_pkg::OFF_SEL11, {16'h0, vin_pkg::FN_MRS});
		drive_check(7'h18, 32'h2000);
		drive_check(7'h10, 32'h2000);
		drive_check(7'h08, 32'h2000);
		wr(vin_pkg::OFF_SEL11, {16'h0, vin_pkg::FN_PID});
		drive_check(7'h11, 32'h0001);
		drive_check(7'h00, 32'h0);
	endtask

	task automatic t_lock;
		wr(vin_pkg::OFF_MODE, 32'h10);
		wr(vin_pkg::OFF_SEL4, {16'h0, vin_pkg::FN_MRS});
		rd_check(vin_pkg::OFF_SEL4, 32'h0000);
		wr(vin_pkg::OFF_MODE, 32'h0);
		wr(vin_pkg::OFF_SEL4, {16'h0, vin_pkg::FN_MRS});
		rd_check(vin_pkg::OFF_SEL4, 32'h0018);
		wr(vin_pkg::OFF_SEL4, {16'h0, vin_pkg::FN_LOW});
	endtask

	task automatic t_modes;
		wr(vin_pkg::OFF_MODE, 32'h1);
		drive_check(7'h07, 32'h0070);
		drive_check(7'h00, 32'h0);
		wr(vin_pkg::OFF_MODE, 32'h2);
		drive_check(7'h07, 32'h0070);
		drive_check(7'h00, 32'h0);
		wr(vin_pkg::OFF_MODE, 32'h4);
		wr(vin_pkg::OFF_SEL11, {16'h0, vin_pkg::FN_SECOND});
		drive_check(7'h11, 32'h0180);
		drive_check(7'h00, 32'h0);
		wr(vin_pkg::OFF_MODE, 32'h0);
	endtask

	task automatic t_run;
		drive_stopped <= 1'b0;
		drive_check(7'h20, 32'h8000);
		rd_check(vin_pkg::OFF_STATUS, 32'h04);
		drive_check(7'h60, 32'h4000);
		drive_check(7'h00, 32'h4000);
		drive_check(7'h40, 32'h10000);
		drive_check(7'h48, 32'h2000);
	endtask

	task automatic t_vf;
		wr(vin_pkg::OFF_SEL11, {16'h0, vin_pkg::FN_VF});
		vf_mask <= 7'h10;
		drive_check(7'h10, 32'h4000);
		rude <= 1'b1;
		drive_check(7'h10, 32'h4000);
		drive_stopped <= 1'b1;
		drive_check(7'h10, 32'h1200);
		drive_check(7'h00, 32'h0);
		rude <= 1'b0;
	endtask

	task automatic t_brake;
		vf_mask <= 7'h00;
		wr(vin_pkg::OFF_SEL11, {16'h0, vin_pkg::FN_SECOND});
		wr(vin_pkg::OFF_MODE, 32'h1000);
		drive_check(7'h00, 32'h20000);
		drive_check(7'h10, 32'h0200);
		drive_check(7'h00, 32'h20000);
		drive_stopped <= 1'b0;
		drive_check(7'h00, 32'h24000);
		drive_check(7'h10, 32'h24000);
		drive_stopped <= 1'b1;
		wr(vin_pkg::OFF_MODE, 32'h0);
		drive_check(7'h00, 32'h0);
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_defaults();
		t_codes();
		t_or_pid();
		t_lock();
		t_modes();
		t_run();
		t_vf();
		t_brake();
		give_verdict();
	end
endmodule
